// [pci_target_lane_mapper.v]
// PCI target channel lane mapper: turns single-beat PCI requests into
// local bus cycles with size code, low address bits and lane placement.
// Assumes requests are already decoded to one image, all inputs are
// synchronous to sys_clk_i and the local slave acknowledges each cycle.
`timescale 1ns/1ps
`include "pci_lane_consts.vh"
`default_nettype none

// Contract
// R1 - Irregular writes become single-byte local writes
// R2 - Little-endian write size codes and offsets
// R3 - Little-endian write lane replication
// R4 - Big-endian write offsets, same size codes
// R5 - Big-endian writes byte-swapped, replicated
// R6 - 16-bit port: word write as two halves
// R7 - 16-bit port: byte/half writes as 32-bit
// R8 - 8-bit port: word/half writes split bytes
// R9 - Little-endian 32-bit reads keep lanes
// R10 - Big-endian 32-bit reads byte-swapped
// R11 - Irregular 32-bit reads as byte reads
// R12 - Little-endian 16-bit port read lanes
// R13 - Big-endian 16-bit port read lanes
// R14 - Irregular 16-bit reads as byte reads
// R15 - Word read from 16-bit port packed
// R16 - Big-endian default, image invert bit
// R17 - Port width from image control field
// R18 - Ascending order, complete after last
module pci_target_lane_mapper #(
    parameter FIFO_DEPTH = `REQ_FIFO_DEPTH
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // PCI side request
    input wire req_valid_i,
    output wire req_ready_o,
    input wire req_write_i,
    input wire [3:0] req_be_n_i,
    input wire [31:0] req_data_i,
    // Image and global configuration
    input wire local_byte_order_bit_i,
    input wire image_endian_invert_i,
    input wire [1:0] port_width_field_i,
    // Local bus cycle
    output reg lb_valid_o,
    output reg lb_write_o,
    output reg [1:0] xfer_size_code_o,
    output reg [1:0] lb_addr_o,
    output reg [31:0] lb_wdata_o,
    input wire lb_ack_i,
    input wire [31:0] lb_rdata_i,
    // PCI side completion
    output reg done_o,
    output reg [31:0] done_rdata_o
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ISSUE = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

////////////////////////////////////////////////////////////////////////
// Helpers

// Lane l of a word, lane 0 being bits 31:24
function [7:0] lane_get;
    input [31:0] d;
    input [1:0] l;
    begin
        case (l)
            2'd0: lane_get = d[31:24];
            2'd1: lane_get = d[23:16];
            2'd2: lane_get = d[15:8];
            default: lane_get = d[7:0];
        endcase
    end
endfunction

// Replace lane l of a word
function [31:0] lane_put;
    input [31:0] d;
    input [1:0] l;
    input [7:0] v;
    begin
        case (l)
            2'd0: lane_put = {v, d[23:0]};
            2'd1: lane_put = {d[31:24], v, d[15:0]};
            2'd2: lane_put = {d[31:16], v, d[7:0]};
            default: lane_put = {d[31:8], v};
        endcase
    end
endfunction

function [31:0] swap32;
    input [31:0] d;
    begin
        swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Request FIFO

wire fifo_valid;
wire fifo_ready;
wire [36:0] fifo_data;
wire f_write;
wire [3:0] f_be_n;
wire [31:0] f_data;

lane_req_fifo #(
    .WIDTH(37),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
) u_req_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i({req_write_i, req_be_n_i, req_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
);

assign f_write = fifo_data[36];
assign f_be_n = fifo_data[35:32];
assign f_data = fifo_data[31:0];

////////////////////////////////////////////////////////////////////////
// Request state

reg [2:0] state_q;
reg little_q;
reg [1:0] width_q;
reg bytes_only_q;
reg [3:0] pend_q;
reg [3:0] cover_q;
reg [31:0] word_q;
reg [31:0] rd_local_q;

assign fifo_ready = (state_q == ST_IDLE);

// Effective order and mask of local offsets for the head request
wire new_little;
wire [3:0] new_en;
wire [3:0] new_mask;
wire new_regular;
wire [31:0] new_word;

assign new_little = (local_byte_order_bit_i ^ image_endian_invert_i)
                    == `ORDER_LITTLE; // [R16]
assign new_en = ~f_be_n;
// Little-endian swaps addressing, big-endian swaps lanes
assign new_mask = new_little ? {new_en[0], new_en[1], new_en[2], new_en[3]}
                             : new_en; // [R2] [R4]
assign new_word = new_little ? f_data : swap32(f_data); // [R5] [R10]
assign new_regular = (new_mask == 4'hf) || (new_mask == 4'h3) ||
                     (new_mask == 4'hc) || (new_mask == 4'h1) ||
                     (new_mask == 4'h2) || (new_mask == 4'h4) ||
                     (new_mask == 4'h8);

////////////////////////////////////////////////////////////////////////
// Next local cycle from the offsets still pending

wire [3:0] src_pend;
wire src_bonly;
wire [31:0] src_word;
wire [1:0] src_width;
reg [1:0] c_size;
reg [1:0] c_addr;
reg [3:0] c_cover;
reg [31:0] c_wdata;
reg [7:0] c_byte;
reg [15:0] c_half;

assign src_pend = (state_q == ST_IDLE) ? new_mask : (pend_q & ~cover_q);
assign src_bonly = (state_q == ST_IDLE)
                   ? (!new_regular || port_width_field_i == `PW_8)
                   : bytes_only_q; // [R1] [R8] [R11] [R14]
assign src_word = (state_q == ST_IDLE) ? new_word : word_q;
assign src_width = (state_q == ST_IDLE) ? port_width_field_i
                                        : width_q; // [R17]

// Word, then aligned halves, then lowest byte first
always @* begin
    c_size = `SZ_BYTE;
    c_addr = 2'd0;
    c_cover = 4'h0;
    c_wdata = 32'h0000_0000;
    c_byte = 8'h00;
    c_half = 16'h0000;
    if (!src_bonly && src_pend == 4'hf &&
        src_width != `PW_16) begin
        c_size = `SZ_WORD; // [R2]
        c_cover = 4'hf;
        c_wdata = src_word;
    end else if (!src_bonly && src_pend[0] && src_pend[1]) begin
        c_size = `SZ_HALF; // [R6] [R15]
        c_cover = 4'h3;
        c_half = src_word[31:16];
        c_wdata = {c_half, 16'h0000};
    end else if (!src_bonly && src_pend[2] && src_pend[3]) begin
        c_size = `SZ_HALF;
        c_addr = 2'd2;
        c_cover = 4'hc;
        c_half = src_word[15:0];
        c_wdata = {c_half, c_half}; // [R3]
    end else begin
        if (src_pend[0]) begin
            c_addr = 2'd0; // [R18]
        end else if (src_pend[1]) begin
            c_addr = 2'd1;
        end else if (src_pend[2]) begin
            c_addr = 2'd2;
        end else begin
            c_addr = 2'd3;
        end
        c_cover = 4'h1 << c_addr; // [R7]
        c_byte = lane_get(src_word, c_addr);
        case (c_addr)
            2'd0: c_wdata = {c_byte, 24'h00_0000};
            2'd1: c_wdata = {c_byte, c_byte, 16'h0000}; // [R3]
            2'd2: c_wdata = {c_byte, 8'h00, c_byte, 8'h00};
            default: c_wdata = {c_byte, c_byte, 8'h00, c_byte};
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Read lane selection for the acknowledged cycle

reg [1:0] rd_src;
reg [31:0] rd_next;

// Source lane depends on port width, destination on offset
always @* begin
    rd_src = 2'd0;
    rd_next = rd_local_q;
    case (xfer_size_code_o)
        `SZ_WORD: rd_next = lb_rdata_i;
        `SZ_HALF: begin
            if (width_q != `PW_16 && lb_addr_o == 2'd2) begin
                rd_next = {rd_local_q[31:16], lb_rdata_i[15:0]}; // [R9]
            end else if (lb_addr_o == 2'd2) begin
                rd_next = {rd_local_q[31:16], lb_rdata_i[31:16]}; // [R12]
            end else begin
                rd_next = {lb_rdata_i[31:16], rd_local_q[15:0]}; // [R13]
            end
        end
        default: begin
            if (width_q == `PW_16) begin
                rd_src = {1'b0, lb_addr_o[0]}; // [R12] [R13]
            end else if (width_q == `PW_8) begin
                rd_src = 2'd0;
            end else begin
                rd_src = lb_addr_o; // [R9] [R10]
            end
            rd_next = lane_put(rd_local_q, lb_addr_o,
                               lane_get(lb_rdata_i, rd_src));
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
// Sequencer

// Load a request, run its local cycles, then signal completion
always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state_q <= ST_IDLE;
        little_q <= 1'b0;
        width_q <= `PW_32;
        bytes_only_q <= 1'b0;
        pend_q <= 4'h0;
        cover_q <= 4'h0;
        word_q <= 32'h0000_0000;
        rd_local_q <= 32'h0000_0000;
        lb_valid_o <= 1'b0;
        lb_write_o <= 1'b0;
        xfer_size_code_o <= `SZ_WORD;
        lb_addr_o <= 2'd0;
        lb_wdata_o <= 32'h0000_0000;
        done_o <= 1'b0;
        done_rdata_o <= 32'h0000_0000;
    end else begin
        done_o <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (fifo_valid) begin
                    little_q <= new_little;
                    width_q <= port_width_field_i;
                    bytes_only_q <= src_bonly;
                    pend_q <= new_mask;
                    word_q <= new_word;
                    rd_local_q <= 32'h0000_0000;
                    lb_write_o <= f_write;
                    if (new_mask == 4'h0) begin
                        state_q <= ST_DONE;
                    end else begin
                        cover_q <= c_cover;
                        xfer_size_code_o <= c_size;
                        lb_addr_o <= c_addr;
                        lb_wdata_o <= c_wdata;
                        lb_valid_o <= 1'b1;
                        state_q <= ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                if (lb_ack_i) begin
                    if (!lb_write_o) begin
                        rd_local_q <= rd_next;
                    end
                    pend_q <= src_pend;
                    if (src_pend == 4'h0) begin
                        lb_valid_o <= 1'b0;
                        state_q <= ST_DONE; // [R18]
                    end else begin
                        cover_q <= c_cover;
                        xfer_size_code_o <= c_size;
                        lb_addr_o <= c_addr;
                        lb_wdata_o <= c_wdata;
                    end
                end
            end
            ST_DONE: begin
                done_o <= 1'b1;
                done_rdata_o <= little_q ? rd_local_q
                                         : swap32(rd_local_q); // [R10]
                state_q <= ST_IDLE;
            end
            default: begin
                lb_valid_o <= 1'b0;
                state_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule // pci_target_lane_mapper
`default_nettype wire

// [pci_lane_consts.vh]
// Constants for the PCI target lane mapper: port width codes, local
// transfer size codes and local byte-order polarity.
// Assumes inclusion by bare name from the mapper, its checker and its bench.
`ifndef PCI_LANE_CONSTS_VH
`define PCI_LANE_CONSTS_VH

// Port width field codes (width of the addressed peripheral port)
`define PW_32 2'b00
`define PW_16 2'b01
`define PW_8 2'b10

// Local bus transfer size codes
`define SZ_WORD 2'b00
`define SZ_BYTE 2'b01
`define SZ_HALF 2'b10

// Effective order after the image invert: 1 means little-endian
`define ORDER_LITTLE 1'b1

// Default depth of the request FIFO
`define REQ_FIFO_DEPTH 8

`endif

// [lane_req_fifo.v]
// Synchronous request FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module lane_req_fifo #(
    parameter WIDTH = 37,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Fill side
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side
    output reg out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

reg [WIDTH-1:0] mem_q [0:DEPTH-1];
reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] rd_ptr_q;
reg [AW:0] count_q;
reg [AW:0] count_d;
wire push;
wire pop;

assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;
assign out_data_o = mem_q[rd_ptr_q];

// Occupancy after this cycle
always @* begin
    count_d = count_q;
    if (push && !pop) begin
        count_d = count_q + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
        count_d = count_q - {{AW{1'b0}}, 1'b1};
    end
end

// Storage array, written only on a push
always @(posedge sys_clk_i) begin
    if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
    end
end

// Pointers and honest full/empty flags
always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        in_ready_o <= 1'b1;
        out_valid_o <= 1'b0;
    end else begin
        if (push) begin
            wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}}
                                                : wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}}
                                                : rd_ptr_q + 1'b1;
        end
        count_q <= count_d;
        in_ready_o <= (count_d != DEPTH);
        out_valid_o <= (count_d != {(AW+1){1'b0}});
    end
end

endmodule // lane_req_fifo
`default_nettype wire

// [lane_mapper_checker.sv]
// Checker for the lane mapper's local cycle and completion ports.
// Assumes one clock domain; bound to every mapper below.
`timescale 1ns/1ps
`include "pci_lane_consts.vh"
`default_nettype none
module lane_mapper_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Config and local cycle
    input wire logic [1:0] port_width_field_i,
    input wire logic lb_valid_o,
    input wire logic lb_write_o,
    input wire logic [1:0] xfer_size_code_o,
    input wire logic [1:0] lb_addr_o,
    input wire logic [31:0] lb_wdata_o,
    input wire logic lb_ack_i,
    // Completion
    input wire logic done_o
);
    // All checks on one clock, off in reset
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // Size, offset and lane shape of each local cycle
    a_half_align: assert property (
        lb_valid_o && xfer_size_code_o == `SZ_HALF |-> !lb_addr_o[0])
        else $error("odd halfword offset");
    a_word_at_zero: assert property (
        lb_valid_o && xfer_size_code_o == `SZ_WORD |-> lb_addr_o == 2'b00)
        else $error("word not at offset zero");
    a_port8_bytes: assert property (
        lb_valid_o && port_width_field_i == `PW_8
        |-> xfer_size_code_o == `SZ_BYTE)
        else $error("wide cycle on byte port");
    a_port16_no_word: assert property (
        lb_valid_o && port_width_field_i == `PW_16
        |-> xfer_size_code_o != `SZ_WORD)
        else $error("word cycle on halfword port");
    a_top_byte_repl: assert property (
        lb_valid_o && lb_write_o && xfer_size_code_o == `SZ_BYTE
        && lb_addr_o == 2'b11 |-> lb_wdata_o[31:24] == lb_wdata_o[7:0]
        && lb_wdata_o[23:16] == lb_wdata_o[7:0] && lb_wdata_o[15:8] == 8'h00)
        else $error("top byte not replicated");
    // Holding, ordering and completion
    a_hold_until_ack: assert property (
        lb_valid_o && !lb_ack_i |=> lb_valid_o && $stable(lb_addr_o)
        && $stable(xfer_size_code_o) && $stable(lb_wdata_o))
        else $error("cycle changed before ack");
    a_split_ascends: assert property (
        (lb_valid_o && lb_ack_i) ##1 lb_valid_o
        |-> lb_addr_o > $past(lb_addr_o))
        else $error("split cycles not ascending");
    a_done_pulse: assert property (
        done_o |-> !$past(lb_valid_o) ##1 !done_o)
        else $error("done early or too long");
endmodule // lane_mapper_checker

bind pci_target_lane_mapper lane_mapper_checker chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .port_width_field_i(port_width_field_i), .lb_valid_o(lb_valid_o),
    .lb_write_o(lb_write_o), .xfer_size_code_o(xfer_size_code_o),
    .lb_addr_o(lb_addr_o), .lb_wdata_o(lb_wdata_o),
    .lb_ack_i(lb_ack_i), .done_o(done_o));
`default_nettype wire

// [lb_slave_model.sv]
// Local bus slave model: acks after a set delay, logs every cycle.
// Assumes the bench sets stall and delay between accesses.
`timescale 1ns/1ps
`default_nettype none
module lb_slave_model (
    // Clock
    input wire logic sys_clk_i,
    // Cycle from the mapper
    input wire logic lb_valid_i,
    input wire logic lb_write_i,
    input wire logic [1:0] size_i,
    input wire logic [1:0] addr_i,
    input wire logic [31:0] wdata_i,
    // Answer
    output logic lb_ack_o,
    output logic [31:0] lb_rdata_o
);
    // Bench knobs and cycle log
    logic stall = 1'b0;
    int delay = 0;
    int wait_q = 0;
    int n = 0;
    logic [31:0] mem = 32'haabbccdd;
    logic lg_wr [128];
    logic [1:0] lg_sz [128];
    logic [1:0] lg_ad [128];
    logic [31:0] lg_wd [128];
    initial begin
        lb_ack_o = 1'b0;
        lb_rdata_o = 32'h5a5a5a5a;
    end
    // Data differs per offset so misplaced lanes show; scrambled after ack
    always @(posedge sys_clk_i) begin
        if (lb_valid_i && lb_ack_o) begin
            lg_wr[n] <= lb_write_i;
            lg_sz[n] <= size_i;
            lg_ad[n] <= addr_i;
            lg_wd[n] <= wdata_i;
            n <= n + 1;
            wait_q <= 0;
            lb_ack_o <= 1'b0;
            lb_rdata_o <= ~lb_rdata_o;
        end else if (lb_valid_i && !stall && wait_q >= delay) begin
            lb_ack_o <= 1'b1;
            lb_rdata_o <= mem ^ {8{2'b00, addr_i}};
        end else if (lb_valid_i) begin
            wait_q <= wait_q + 1;
        end
    end
endmodule // lb_slave_model
`default_nettype wire

// [tb_pci_target_lane_mapper.sv]
// Bench for the lane mapper: write maps, splits, reads, FIFO fill.
// Assumes the slave model and the bound checker compile with it.
`timescale 1ns/1ps
`include "pci_lane_consts.vh"
`default_nettype none
module tb_pci_target_lane_mapper;
    // Bench signals
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [3:0] req_be_n_i = 4'hf;
    logic [31:0] req_data_i = 32'h44332211;
    logic local_byte_order_bit_i = 1'b0;
    logic image_endian_invert_i = 1'b0;
    logic [1:0] port_width_field_i = 2'b00;
    logic req_ready_o, lb_valid_o, lb_write_o, lb_ack_i, done_o;
    logic [1:0] xfer_size_code_o, lb_addr_o;
    logic [31:0] lb_wdata_o, lb_rdata_i, done_rdata_o;
    int err_count = 0;
    int check_count = 0;
    int base = 0;
    // Clock at 50 MHz
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // Mapper and local slave
    pci_target_lane_mapper dut (.sys_clk_i, .rst_n_i, .req_valid_i,
        .req_ready_o, .req_write_i, .req_be_n_i, .req_data_i,
        .local_byte_order_bit_i, .image_endian_invert_i,
        .port_width_field_i, .lb_valid_o, .lb_write_o, .xfer_size_code_o,
        .lb_addr_o, .lb_wdata_o, .lb_ack_i, .lb_rdata_i, .done_o,
        .done_rdata_o);
    lb_slave_model sl (.sys_clk_i, .lb_valid_i(lb_valid_o),
        .lb_write_i(lb_write_o), .size_i(xfer_size_code_o),
        .addr_i(lb_addr_o), .wdata_i(lb_wdata_o), .lb_ack_o(lb_ack_i),
        .lb_rdata_o(lb_rdata_i));
    ////////////////////////////////////////
    // Verdict and comparisons
    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Count and shape {size, offset, write data} of logged cycles
    task automatic seq(input int n, input logic [35:0] e [4]);
        cmp(36'(sl.n - base), 36'(n));
        for (int i = 0; i < n; i++) begin
            cmp({sl.lg_sz[base+i], sl.lg_ad[base+i],
                sl.lg_wr[base+i] ? sl.lg_wd[base+i] : 32'h0}, e[i]);
        end
    endtask
    // One request, then a bounded wait for its done pulse
    task automatic run(input logic wr, input logic [3:0] be,
        input logic [1:0] w, input logic ob, input logic inv);
        int k;
        base = sl.n;
        @(posedge sys_clk_i);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_be_n_i <= be;
        port_width_field_i <= w;
        local_byte_order_bit_i <= ob;
        image_endian_invert_i <= inv;
        @(posedge sys_clk_i);
        while (req_ready_o !== 1'b1) @(posedge sys_clk_i);
        req_valid_i <= 1'b0;
        k = 0;
        while (done_o !== 1'b1 && k < 300) begin
            @(posedge sys_clk_i);
            k++;
        end
        cmp(36'(k < 300), 36'h1);
    endtask
    ////////////////////////////////////////
    // Scenarios
    task automatic t_write32();
        logic [39:0] le [7] = '{40'h7444000000, 40'hb533330000,
            40'hd622002200, 40'he711110011, 40'h3844330000,
            40'hca22112211, 40'h0044332211};
        logic [39:0] be [7] = '{40'he411000000, 40'hd522220000,
            40'hb633003300, 40'h7744440044, 40'hc811220000,
            40'h3a33443344, 40'h0011223344};
        for (int i = 0; i < 7; i++) begin
            run(1'b1, le[i][39:36], `PW_32, 1'b0, 1'b1);
            seq(1, '{le[i][35:0], 0, 0, 0});
            run(1'b1, be[i][39:36], `PW_32, i[0], i[0]);
            seq(1, '{be[i][35:0], 0, 0, 0});
        end
    endtask
    task automatic t_split();
        run(1'b1, 4'h0, `PW_16, 1'b1, 1'b0);
        seq(2, '{36'h844330000, 36'ha22112211, 0, 0});
        run(1'b1, 4'he, `PW_16, 1'b1, 1'b0);
        seq(1, '{36'h711110011, 0, 0, 0});
        run(1'b1, 4'h0, `PW_8, 1'b0, 1'b0);
        seq(4, '{36'h411000000, 36'h522220000, 36'h633003300,
            36'h744440044});
        run(1'b1, 4'h3, `PW_8, 1'b1, 1'b0);
        seq(2, '{36'h444000000, 36'h533330000, 0, 0});
        run(1'b1, 4'h5, `PW_32, 1'b1, 1'b0);
        seq(2, '{36'h444000000, 36'h622002200, 0, 0});
        // No enabled byte: done without any local cycle
        run(1'b1, 4'hf, `PW_32, 1'b0, 1'b0);
        seq(0, '{0, 0, 0, 0});
    endtask
    task automatic t_reads();
        sl.delay = 2;
        run(1'b0, 4'h0, `PW_32, 1'b1, 1'b0);
        cmp({4'h0, done_rdata_o}, 36'haabbccdd);
        run(1'b0, 4'h0, `PW_32, 1'b0, 1'b0);
        cmp({4'h0, done_rdata_o}, 36'hddccbbaa);
        run(1'b0, 4'h0, `PW_16, 1'b0, 1'b0);
        seq(2, '{36'h800000000, 36'ha00000000, 0, 0});
        cmp({4'h0, done_rdata_o}, 36'h9988bbaa);
        run(1'b0, 4'hb, `PW_16, 1'b1, 1'b0);
        cmp({4'h0, done_rdata_o}, 36'h00aa0000);
        // Upper-offset halfword from a 32-bit port keeps its lanes
        run(1'b0, 4'hc, `PW_32, 1'b1, 1'b0);
        seq(1, '{36'ha00000000, 0, 0, 0});
        cmp({4'h0, done_rdata_o}, 36'h0000eeff);
        run(1'b0, 4'h6, `PW_32, 1'b1, 1'b0);
        seq(2, '{36'h400000000, 36'h700000000, 0, 0});
        cmp({4'h0, done_rdata_o}, 36'haa0000ee);
        run(1'b0, 4'ha, `PW_16, 1'b0, 1'b0);
        cmp({4'h0, done_rdata_o}, 36'h008800aa);
        sl.delay = 0;
    endtask
    // Stall the slave, fill the request FIFO, then drain it
    task automatic t_fill();
        int taken = 0;
        int k = 0;
        int d = 0;
        base = sl.n;
        sl.stall = 1'b1;
        @(posedge sys_clk_i);
        req_valid_i <= 1'b1;
        req_write_i <= 1'b1;
        req_be_n_i <= 4'h0;
        port_width_field_i <= `PW_16;
        repeat (14) begin
            @(posedge sys_clk_i);
            if (req_ready_o === 1'b1) taken++;
        end
        req_valid_i <= 1'b0;
        cmp(36'(taken), 36'd9);
        sl.stall = 1'b0;
        while (d < 9 && k < 600) begin
            @(posedge sys_clk_i);
            k++;
            if (done_o === 1'b1) d++;
        end
        cmp(36'(d), 36'd9);
        // Each word on the 16-bit port goes out as two halves
        cmp(36'(sl.n - base), 36'd18);
    endtask
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        cmp({33'h0, lb_valid_o, done_o, req_ready_o}, 36'h1);
        t_write32();
        t_split();
        t_reads();
        t_fill();
        report_and_stop();
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // tb_pci_target_lane_mapper
`default_nettype wire
